// file: pkg/pxo_pkg.sv
// Constants shared by the proximity result / offset block and its offset scaler.
// Assumes a single 40 MHz system clock; register addresses are the device's own byte addresses.
package pxo_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_PROX_RESULT_LOW  = 8'h18;
  localparam logic [7:0] ADDR_PROX_RESULT_HIGH = 8'h19;
  localparam logic [7:0] ADDR_PROX_OFFSET      = 8'h1e;

  // Offset register layout
  localparam int         OFFSET_SIGN_BIT = 7;
  localparam int         OFFSET_MAG_MSB  = 6;
  localparam logic [7:0] OFFSET_RESET    = 8'h00;

  // Reset values of data holders
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0]  SHADOW_RESET = 8'h00;
  localparam logic [7:0]  RDATA_RESET  = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

  // Scaled offset width: 7-bit magnitude, up to 8x gain, times 8-bit pulse count
  localparam int SCALED_W = 18;
  localparam logic [SCALED_W-1:0] SCALED_RESET = 18'h00000;
  localparam logic [15:0] RESULT_MAX = 16'hffff;

  // LED pulse timing
  localparam int CLK_HZ            = 40000000;
  localparam int PULSE_RATE_HZ     = 62500;
  localparam int PULSE_PERIOD_CYC  = CLK_HZ / PULSE_RATE_HZ;
  localparam int PULSE_HALF_CYC    = PULSE_PERIOD_CYC / 2;
  localparam int PHASE_W           = 10;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(PULSE_HALF_CYC - 1);
  localparam logic [PHASE_W-1:0] PHASE_RESET = 10'h000;
  localparam logic [7:0] PULSE_CNT_RESET = 8'h00;

  // LED burst sequencer states
  typedef enum logic [1:0] {BURST_IDLE, BURST_HIGH, BURST_LOW} pxo_burst_t;

endpackage : pxo_pkg

// file: pkg/pxo_offset_if.sv
// Carrier between the result block and its offset scaler.
// Assumes both ends run on the same system clock.
interface pxo_offset_if;
  logic [7:0]                   offset_reg;   // Sign-magnitude offset
  logic [1:0]                   gain_sel;     // Proximity gain code
  logic [1:0]                   drive_sel;    // LED drive strength code
  logic [7:0]                   pulse_count;  // Pulses per accumulation
  logic [pxo_pkg::SCALED_W-1:0] scaled_mag;   // Effective offset magnitude

  modport owner  (output offset_reg, output gain_sel, output drive_sel, output pulse_count, input scaled_mag);
  modport scaler (input offset_reg, input gain_sel, input drive_sel, input pulse_count, output scaled_mag);
endinterface : pxo_offset_if

// file: hw/pxo_offset_scaler.sv
// Scales the offset magnitude by gain, LED drive strength and pulse count.
// Assumes settings change slowly; the result lags the inputs by one cycle.
module pxo_offset_scaler (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // Offset settings
  pxo_offset_if.scaler ofs
);

  logic [pxo_pkg::SCALED_W-1:0] scaled_ff;
  logic [pxo_pkg::SCALED_W-1:0] nxt_scaled;
  logic [9:0]                   gained;
  logic [17:0]                  pulsed;

  // Gain doubles per code step, drive halves per code step (100, 50, 25, 12.5 mA)
  always_comb
  begin
    gained     = {3'h0, ofs.offset_reg[pxo_pkg::OFFSET_MAG_MSB:0]} << ofs.gain_sel; // R8 R10
    pulsed     = {8'h00, gained} * {10'h000, ofs.pulse_count};                     // R8
    nxt_scaled = pulsed >> ofs.drive_sel;                                           // R8
  end

  // Registered so the wide multiply stays off the result path
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      scaled_ff <= pxo_pkg::SCALED_RESET;
    else if (CE_I)
      scaled_ff <= nxt_scaled;
  end

  assign ofs.scaled_mag = scaled_ff;

endmodule // pxo_offset_scaler

// file: hw/pxo_prox_result_offset.sv
// Proximity result registers with coherent two-byte read, offset register and LED pulse burst.
// Assumes the register port comes from the serial slave front end on the same clock,
// and the raw count and controls come from same-clock measurement logic.
// Behaviour
// R1: Result is 16 bits, low byte at 0x18, high byte at 0x19.
// R2: Reading the low byte copies the current high byte into a shadow.
// R3: A high byte read after a low byte read returns the shadow.
// R4: Shadow holds even if new results land between the two reads.
// R5: Host should read both bytes in one auto-increment transfer, low first.
// R6: Offset register is 8-bit sign-magnitude, bit 7 sign, bits 6:0 magnitude.
// R7: Sign zero subtracts the offset, sign one adds it.
// R8: Offset amount scales with gain, LED drive strength and pulse count.
// R9: Host may average results and tune the offset in a closed loop.
// R10: Gain codes 00 to 11 select 1x, 2x, 4x, 8x.
// R11: Accumulation emits the programmed number of LED pulses at 62.5 kHz.
// R12: Offset applied to raw count before loading, saturating at 0 and 0xffff.
module pxo_prox_result_offset (
  // Clock, reset, enable
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  input  wire logic        CE_I,
  // Register access port
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic        REG_WR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_RD_I,
  output logic      [7:0]  REG_RDATA_O,
  // Settings held elsewhere in the device
  input  wire logic [1:0]  PROX_GAIN_SELECT_I,
  input  wire logic [1:0]  LED_DRIVE_STRENGTH_I,
  input  wire logic [7:0]  PROX_PULSE_COUNT_I,
  // Measurement path
  input  wire logic        ACCUM_START_I,
  input  wire logic        RAW_VALID_I,
  input  wire logic [15:0] RAW_COUNT_I,
  // Outputs
  output logic             LED_PULSE_O,
  output logic             ACCUM_BUSY_O,
  output logic      [15:0] PROX_RESULT_O,
  output logic             RESULT_VALID_O
);

  pxo_offset_if ofs ();

  // Register state
  logic [7:0]  prox_offset_register_ff;
  logic [7:0]  nxt_prox_offset_register;
  logic [15:0] result_ff;
  logic [15:0] nxt_result;
  logic [7:0]  shadow_ff;
  logic [7:0]  nxt_shadow;
  logic        shadow_armed_ff;
  logic        nxt_shadow_armed;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        valid_ff;
  logic        nxt_valid;
  logic [16:0] sum;
  logic [15:0] adjusted;

  // Burst state
  pxo_pkg::pxo_burst_t       state_ff;
  pxo_pkg::pxo_burst_t       nxt_state;
  logic [pxo_pkg::PHASE_W-1:0] phase_ff;
  logic [pxo_pkg::PHASE_W-1:0] nxt_phase;
  logic [7:0]                remain_ff;
  logic [7:0]                nxt_remain;
  logic                      led_ff;
  logic                      nxt_led;
  logic                      busy_ff;
  logic                      nxt_busy;

  // Scaler settings
  assign ofs.offset_reg  = prox_offset_register_ff;
  assign ofs.gain_sel    = PROX_GAIN_SELECT_I;
  assign ofs.drive_sel   = LED_DRIVE_STRENGTH_I;
  assign ofs.pulse_count = PROX_PULSE_COUNT_I;

  pxo_offset_scaler u_scaler (
    .CLK_SYS_I (CLK_SYS_I),
    .RESET_I   (RESET_I),
    .CE_I      (CE_I),
    .ofs       (ofs.scaler)
  );

  // Offset applied with clamping; wrap would turn a near object into a far one
  always_comb
  begin
    sum      = {1'b0, RAW_COUNT_I} + {1'b0, ofs.scaled_mag[15:0]};
    adjusted = RAW_COUNT_I;
    if (ofs.offset_reg[pxo_pkg::OFFSET_SIGN_BIT]) // R7
    begin
      if (sum[16] || (ofs.scaled_mag[17:16] != 2'h0)) // R12
        adjusted = pxo_pkg::RESULT_MAX;
      else
        adjusted = sum[15:0];
    end
    else
    begin
      if (ofs.scaled_mag >= {2'h0, RAW_COUNT_I}) // R12
        adjusted = pxo_pkg::RESULT_MAX - pxo_pkg::RESULT_MAX;
      else
        adjusted = RAW_COUNT_I - ofs.scaled_mag[15:0];
    end
  end

  // Register reads, writes, result load and shadow capture
  always_comb
  begin
    nxt_prox_offset_register = prox_offset_register_ff;
    nxt_result               = result_ff;
    nxt_shadow               = shadow_ff;
    nxt_shadow_armed         = shadow_armed_ff;
    nxt_rdata                = rdata_ff;
    nxt_valid                = valid_ff;
    if (RAW_VALID_I)
    begin
      nxt_result = adjusted; // R12
      nxt_valid  = 1'b1;
    end
    if (REG_WR_I && (REG_ADDR_I == pxo_pkg::ADDR_PROX_OFFSET))
      nxt_prox_offset_register = REG_WDATA_I; // R6
    if (REG_RD_I)
    begin
      if (REG_ADDR_I == pxo_pkg::ADDR_PROX_RESULT_LOW)
      begin
        nxt_rdata        = result_ff[7:0];  // R1
        nxt_shadow       = result_ff[15:8]; // R2
        nxt_shadow_armed = 1'b1;
      end
      else if (REG_ADDR_I == pxo_pkg::ADDR_PROX_RESULT_HIGH)
      begin
        // Live value only when no low read came first
        nxt_rdata        = shadow_armed_ff ? shadow_ff : result_ff[15:8]; // R1 R3 R4
        nxt_shadow_armed = 1'b0;
      end
      else if (REG_ADDR_I == pxo_pkg::ADDR_PROX_OFFSET)
        nxt_rdata = prox_offset_register_ff; // R6
      else
        nxt_rdata = pxo_pkg::UNMAPPED_DATA;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      prox_offset_register_ff <= pxo_pkg::OFFSET_RESET;
      result_ff               <= pxo_pkg::RESULT_RESET;
      shadow_ff               <= pxo_pkg::SHADOW_RESET;
      shadow_armed_ff         <= 1'b0;
      rdata_ff                <= pxo_pkg::RDATA_RESET;
      valid_ff                <= 1'b0;
    end
    else if (CE_I)
    begin
      prox_offset_register_ff <= nxt_prox_offset_register;
      result_ff               <= nxt_result;
      shadow_ff               <= nxt_shadow;
      shadow_armed_ff         <= nxt_shadow_armed;
      rdata_ff                <= nxt_rdata;
      valid_ff                <= nxt_valid;
    end
  end

  // LED burst: half period high, half period low, per programmed pulse
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_phase  = phase_ff;
    nxt_remain = remain_ff;
    case (state_ff)
      pxo_pkg::BURST_IDLE:
      begin
        // A zero count yields no pulses and no busy time
        if (ACCUM_START_I && (PROX_PULSE_COUNT_I != pxo_pkg::PULSE_CNT_RESET))
        begin
          nxt_state  = pxo_pkg::BURST_HIGH; // R11
          nxt_remain = PROX_PULSE_COUNT_I;  // R11
          nxt_phase  = pxo_pkg::PHASE_RESET;
        end
      end
      pxo_pkg::BURST_HIGH:
      begin
        if (phase_ff == pxo_pkg::PHASE_LAST) // R11
        begin
          nxt_state = pxo_pkg::BURST_LOW;
          nxt_phase = pxo_pkg::PHASE_RESET;
        end
        else
          nxt_phase = phase_ff + 1'b1;
      end
      pxo_pkg::BURST_LOW:
      begin
        if (phase_ff == pxo_pkg::PHASE_LAST)
        begin
          nxt_phase  = pxo_pkg::PHASE_RESET;
          nxt_remain = remain_ff - 1'b1;
          nxt_state  = (remain_ff == 8'h01) ? pxo_pkg::BURST_IDLE : pxo_pkg::BURST_HIGH; // R11
        end
        else
          nxt_phase = phase_ff + 1'b1;
      end
      default:
        nxt_state = pxo_pkg::BURST_IDLE;
    endcase
    nxt_led  = (nxt_state == pxo_pkg::BURST_HIGH);
    nxt_busy = (nxt_state != pxo_pkg::BURST_IDLE);
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      state_ff  <= pxo_pkg::BURST_IDLE;
      phase_ff  <= pxo_pkg::PHASE_RESET;
      remain_ff <= pxo_pkg::PULSE_CNT_RESET;
      led_ff    <= 1'b0;
      busy_ff   <= 1'b0;
    end
    else if (CE_I)
    begin
      state_ff  <= nxt_state;
      phase_ff  <= nxt_phase;
      remain_ff <= nxt_remain;
      led_ff    <= nxt_led;
      busy_ff   <= nxt_busy;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA_O    = rdata_ff;
  assign PROX_RESULT_O  = result_ff;
  assign RESULT_VALID_O = valid_ff;
  assign LED_PULSE_O    = led_ff;
  assign ACCUM_BUSY_O   = busy_ff;

endmodule // pxo_prox_result_offset

// file: sim/pxo_chk.sv
// Port checker for the proximity result / offset block.
// Assumes one clock domain; bound to the top module from the bench.
module pxo_chk (
  // Clock, reset, enable
  input wire logic        CLK_SYS_I,
  input wire logic        RESET_I,
  input wire logic        CE_I,
  // Register port
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic        REG_WR_I,
  input wire logic [7:0]  REG_WDATA_I,
  input wire logic        REG_RD_I,
  input wire logic [7:0]  REG_RDATA_O,
  // Settings
  input wire logic [1:0]  PROX_GAIN_SELECT_I,
  input wire logic [1:0]  LED_DRIVE_STRENGTH_I,
  input wire logic [7:0]  PROX_PULSE_COUNT_I,
  // Measurement path and burst
  input wire logic        ACCUM_START_I,
  input wire logic        RAW_VALID_I,
  input wire logic [15:0] RAW_COUNT_I,
  input wire logic        LED_PULSE_O,
  input wire logic        ACCUM_BUSY_O,
  input wire logic [15:0] PROX_RESULT_O,
  input wire logic        RESULT_VALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  // Register reads: low byte, shadowed high byte, unmapped, hold
  rd_low_a: assert property (
    REG_RD_I && CE_I && REG_ADDR_I == 8'h18 |=> REG_RDATA_O == $past(PROX_RESULT_O[7:0])) else $error("low byte bad");
  shadow_hold_a: assert property (
    REG_RD_I && CE_I && REG_ADDR_I == 8'h18 ##1 REG_RD_I && CE_I && REG_ADDR_I == 8'h19
    |=> REG_RDATA_O == $past(PROX_RESULT_O[15:8], 2)) else $error("high byte not shadowed");
  unmapped_read_a: assert property (
    REG_RD_I && CE_I && !(REG_ADDR_I inside {8'h18, 8'h19, 8'h1e}) |=> REG_RDATA_O == 8'h00) else $error("unmapped");
  rdata_hold_a: assert property (
    !(REG_RD_I && CE_I) |=> $stable(REG_RDATA_O)) else $error("read data moved");
  // Result load and its valid flag stays up
  valid_sticky_a: assert property (
    RAW_VALID_I && CE_I |=> RESULT_VALID_O [*3]) else $error("valid not sticky");
  // LED burst start, pulse width and quiet when idle
  burst_start_a: assert property (
    ACCUM_START_I && CE_I && !ACCUM_BUSY_O && PROX_PULSE_COUNT_I != 8'h00 |=> LED_PULSE_O && ACCUM_BUSY_O)
    else $error("burst did not start");
  pulse_width_a: assert property (
    $rose(LED_PULSE_O) |-> ##300 LED_PULSE_O ##19 LED_PULSE_O ##1 !LED_PULSE_O) else $error("pulse width");
  led_idle_a: assert property (
    !ACCUM_BUSY_O |-> !LED_PULSE_O) else $error("LED on while idle");
endmodule // pxo_chk

// file: sim/pxo_host_model.sv
// Host model: issues register reads and writes as the serial front end would.
// Assumes the bench calls its tasks; released lines show inverted values.
module pxo_host_model (
  // Clock
  input  wire logic       CLK_SYS_I,
  // Register port
  output logic      [7:0] REG_ADDR_O,
  output logic            REG_WR_O,
  output logic      [7:0] REG_WDATA_O,
  output logic            REG_RD_O,
  input  wire logic [7:0] REG_RDATA_I
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle from time zero
  initial
  begin
    REG_ADDR_O = 8'h00;
    REG_WR_O = 1'b0;
    REG_WDATA_O = 8'h00;
    REG_RD_O = 1'b0;
  end
  // One write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS_I);
    REG_ADDR_O <= a;
    REG_WDATA_O <= d;
    REG_WR_O <= 1'b1;
    @(posedge CLK_SYS_I);
    REG_WR_O <= 1'b0;
    REG_ADDR_O <= ~a;
    REG_WDATA_O <= ~d;
  endtask
  // One read strobe, data taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_SYS_I);
    REG_ADDR_O <= a;
    REG_RD_O <= 1'b1;
    @(posedge CLK_SYS_I);
    REG_RD_O <= 1'b0;
    REG_ADDR_O <= ~a;
    #1 d = REG_RDATA_I;
  endtask
  // Two-byte burst, low byte first, back to back
  task automatic rd2(output logic [7:0] lo, output logic [7:0] hi);
    @(posedge CLK_SYS_I);
    REG_ADDR_O <= 8'h18;
    REG_RD_O <= 1'b1;
    @(posedge CLK_SYS_I);
    REG_ADDR_O <= 8'h19;
    #1 lo = REG_RDATA_I;
    @(posedge CLK_SYS_I);
    REG_RD_O <= 1'b0;
    REG_ADDR_O <= 8'he6;
    #1 hi = REG_RDATA_I;
  endtask
endmodule // pxo_host_model

// file: sim/tb.sv
// Self-checking bench for the proximity result / offset block.
// Assumes the host model drives the register port; bench drives the rest.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, start = 1'b0, rv = 1'b0;
  logic [1:0]  gain = 2'h0, drive = 2'h0;
  logic [7:0]  pulses = 8'h01, addr, wdata, rdata, lo, hi;
  logic        wr, rd, led, busy, valid;
  logic [15:0] raw = 16'h0000, res;
  int          errors = 0, total_checks = 0, n, m;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  pxo_host_model host_u (.CLK_SYS_I(clk), .REG_ADDR_O(addr), .REG_WR_O(wr), .REG_WDATA_O(wdata),
    .REG_RD_O(rd), .REG_RDATA_I(rdata));
  pxo_prox_result_offset dut_u (.CLK_SYS_I(clk), .RESET_I(rst), .CE_I(ce), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .PROX_GAIN_SELECT_I(gain),
    .LED_DRIVE_STRENGTH_I(drive), .PROX_PULSE_COUNT_I(pulses), .ACCUM_START_I(start), .RAW_VALID_I(rv),
    .RAW_COUNT_I(raw), .LED_PULSE_O(led), .ACCUM_BUSY_O(busy), .PROX_RESULT_O(res), .RESULT_VALID_O(valid));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Settings; scaler lags, so allow a few cycles
  task automatic set(input logic [1:0] g, input logic [1:0] d, input logic [7:0] p);
    @(posedge clk);
    gain <= g;
    drive <= d;
    pulses <= p;
    repeat (3) @(posedge clk);
  endtask
  // One raw count, result sampled once loaded
  task automatic load(input logic [15:0] r);
    @(posedge clk);
    raw <= r;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    raw <= ~r;
    #1;
  endtask
  // Offset register, read-only result, unmapped address
  task automatic t_regs;
    #1 chk(valid, 1'b0);
    host_u.rd(8'h1e, lo);
    chk(lo, 8'h00);
    host_u.wr(8'h1e, 8'ha5);
    host_u.rd(8'h1e, lo);
    chk(lo, 8'ha5);
    // Enable low freezes the register, so this write must not land
    ce <= 1'b0;
    host_u.wr(8'h1e, 8'h3c);
    ce <= 1'b1;
    host_u.rd(8'h1e, lo);
    chk(lo, 8'ha5);
    host_u.wr(8'h18, 8'h5a);
    host_u.rd(8'h18, lo);
    chk(lo, 8'h00);
    host_u.rd(8'h33, lo);
    chk(lo, 8'h00);
    $display("test regs done");
  endtask
  // Sign, every gain code, drive shift, both saturation ends
  task automatic t_offset;
    host_u.wr(8'h1e, 8'h85);
    for (int g = 0; g < 4; g++)
    begin
      set(2'(g), 2'h0, 8'h01);
      load(16'h0100);
      chk(res, 16'h0100 + (16'h0005 << g));
    end
    chk(valid, 1'b1);
    set(2'h3, 2'h2, 8'h03);
    load(16'h0100);
    chk(res, 16'h011e);
    load(16'hfffe);
    chk(res, 16'hffff);
    host_u.wr(8'h1e, 8'h05);
    set(2'h0, 2'h0, 8'h01);
    load(16'h0105);
    chk(res, 16'h0100);
    load(16'h0003);
    chk(res, 16'h0000);
    $display("test offset done");
  endtask
  // New result lands during and between the two byte reads
  task automatic t_shadow;
    host_u.wr(8'h1e, 8'h00);
    set(2'h0, 2'h0, 8'h01);
    load(16'h1234);
    fork
      host_u.rd2(lo, hi);
      load(16'habcd);
    join
    chk(lo, 8'h34);
    chk(hi, 8'h12);
    host_u.rd(8'h18, lo);
    load(16'h5678);
    host_u.rd(8'h19, hi);
    chk({hi, lo}, 16'habcd);
    $display("test shadow done");
  endtask
  // Host averages four results, then trims the offset to cancel their mean
  task automatic t_loop;
    int acc;
    acc = 0;
    host_u.wr(8'h1e, 8'h00);
    set(2'h0, 2'h0, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      load(16'h0010 + 16'(2 * i));
      host_u.rd2(lo, hi);
      acc += {hi, lo};
    end
    chk(16'(acc), 16'h004c);
    host_u.wr(8'h1e, 8'(acc / 4));
    set(2'h0, 2'h0, 8'h01);
    load(16'h0020);
    chk(res, 16'h000d);
    $display("test loop done");
  endtask
  // Mid-run reset clears result, valid flag and offset
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 chk(res, pxo_pkg::RESULT_RESET);
    chk(valid, 1'b0);
    host_u.rd(8'h1e, lo);
    chk(lo, pxo_pkg::OFFSET_RESET);
    $display("test reset done");
  endtask
  // Two-pulse burst, then a refused start with zero pulses
  task automatic t_led;
    set(2'h0, 2'h0, 8'h02);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    m = 0;
    repeat (1400)
    begin
      #1 n += led;
      m += busy;
      @(posedge clk);
    end
    chk(16'(n), 16'd640);
    chk(16'(m), 16'd1280);
    set(2'h0, 2'h0, 8'h00);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    #1 chk(busy, 1'b0);
    $display("test led done");
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_offset;
    t_shadow;
    t_loop;
    t_reset;
    t_led;
    wrap_up;
  end
  // Watchdog well past the expected run length
  initial
  begin
    #200us;
    errors++;
    wrap_up;
  end
endmodule // tb
bind pxo_prox_result_offset pxo_chk chk_u (.*);
